// *** core/pcs_tx_fifo_10g_params.svh ***
// Constants of the transmit FIFO: register offsets, reset values and timing counts.
// Assumes inclusion by bare name from the FIFO package and the FIFO module.
`ifndef PCS_TX_FIFO_10G_PARAMS_SVH
`define PCS_TX_FIFO_10G_PARAMS_SVH

// Storage geometry
`define TXF_WIDTH 73
`define TXF_DEPTH 32
`define TXF_AW 5
`define TXF_LW 6
`define TXF_DATA_W 64
`define TXF_CTRL_W 9

// Register offsets (byte addresses on the plain register port)
`define TXF_OFS_CTRL 8'h00
`define TXF_OFS_THR_FULL 8'h04
`define TXF_OFS_THR_EMPTY 8'h08
`define TXF_OFS_THR_PFULL 8'h0C
`define TXF_OFS_THR_PEMPTY 8'h10
`define TXF_OFS_STATUS 8'h14
`define TXF_OFS_IRQ_STAT 8'h18
`define TXF_OFS_IRQ_CLR 8'h1C
`define TXF_OFS_IRQ_EN 8'h20

// Status register field positions
`define TXF_STAT_LVL_LSB 0
`define TXF_STAT_FLAG_LSB 8

// Reset values
`define TXF_RST_CTRL 8'h00
`define TXF_RST_THR_FULL 5'h1F
`define TXF_RST_THR_EMPTY 5'h00
`define TXF_RST_THR_PFULL 5'h17
`define TXF_RST_THR_PEMPTY 5'h08
`define TXF_RST_IRQ_EN 2'h0

// Reload of the empty stretch counter; the flag stays up two cycles after its cause has gone
`define TXF_EMPTY_STRETCH 3'h3

`endif

// *** core/pcs_tx_fifo_10g_pkg.sv ***
// Types shared by the transmit FIFO: modes, fabric widths, control layout, flags.
// Assumes the constants header is on the include path.
`include "pcs_tx_fifo_10g_params.svh"

package pcs_tx_fifo_10g_pkg;

	typedef enum logic [1:0] {
		MODE_INTERLAKEN,
		MODE_PHASE_COMP,
		MODE_REGISTER
	} fifo_mode_t;

	typedef enum logic [2:0] {
		FAB_W32,
		FAB_W40,
		FAB_W50,
		FAB_W64,
		FAB_W66,
		FAB_W67
	} fabric_width_t;

	typedef enum logic [1:0] {
		PMA_W32,
		PMA_W40,
		PMA_W64
	} pma_width_t;

	// Control register layout, lowest field in the low bits
	typedef struct packed {
		logic invert;
		pma_width_t pma_width;
		fabric_width_t fabric_width;
		fifo_mode_t mode;
	} ctrl_reg_t;

	typedef struct packed {
		logic partial_empty;
		logic partial_full;
		logic empty;
		logic full;
	} fifo_flags_t;

	typedef struct packed {
		logic [`TXF_CTRL_W-1:0] ctrl;
		logic [`TXF_DATA_W-1:0] data;
	} tx_word_t;

endpackage

// *** core/pcs_tx_fifo_10g.sv ***
// Transmit FIFO at the entry of the 10G PCS: 32 x 73-bit store, three modes, flags, interrupts.
// Assumes writer and frame generator share i_clk and drive their strobes from flops.
`timescale 1ns/1ns
`include "pcs_tx_fifo_10g_params.svh"

// Functional notes
// R1: Store holds 32 words of 73 bits; write and read sides kept separate.
// R2: Full, empty, partial full and partial empty flags against programmable thresholds.
// R3: Interlaken mode is elastic: writer may outpace reader, overflow is refused.
// R4: Writer gates writes with word valid and watches flags to avoid over/underrun.
// R5: Interlaken reads come only from the frame generator read request.
// R6: Phase compensation mode drains every cycle a word is held, equal rates.
// R7: Register mode bypasses the store; word and valid pass one register stage.
// R8: Writer paces valid exactly to the gearbox ratio in register mode.
// R9: 66-bit fabric width takes 64 data bits plus two low control bits.
// R10: 67-bit fabric width takes 64 data bits plus three low control bits.
// R11: PMA width 32/40/64 and fabric width 32/40/50/64/66/67 are selectable.
// R12: Outgoing word may be bitwise inverted at run time.
// R13: Full at or above, empty at or below threshold; partial flags likewise.
// R14: Full threshold 0..31, default 31, active high, on the write clock.
// R15: Empty threshold 0..31, default 0.
// R16: Partial full threshold 0..31, default 23, active high, on write clock.
// R17: Empty flag is pulse-stretched and timed by the read side.
module pcs_tx_fifo_10g (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [`TXF_DATA_W-1:0] i_tx_data,
	input wire logic [`TXF_CTRL_W-1:0] i_tx_ctrl,
	input wire logic i_tx_data_valid,
	input wire logic i_rd_req,
	output logic [`TXF_WIDTH-1:0] o_tx_word,
	output logic o_tx_word_valid,
	output logic [1:0] o_pma_width,
	output logic o_transmit_fifo_full_flag,
	output logic o_transmit_fifo_partial_full_flag,
	output logic o_transmit_fifo_empty_flag,
	output logic o_transmit_fifo_partial_empty_flag,
	output logic o_irq,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata
);

	// Shape the fabric word to the selected width; unused lanes read as zero
	function automatic pcs_tx_fifo_10g_pkg::tx_word_t form_word(
		input pcs_tx_fifo_10g_pkg::fabric_width_t w,
		input logic [`TXF_DATA_W-1:0] d,
		input logic [`TXF_CTRL_W-1:0] c
	);
		pcs_tx_fifo_10g_pkg::tx_word_t r;
		r.data = d;
		r.ctrl = '0;
		case (w)
			pcs_tx_fifo_10g_pkg::FAB_W32: r.data = {32'h0, d[31:0]};
			pcs_tx_fifo_10g_pkg::FAB_W40: r.data = {24'h0, d[39:0]};
			pcs_tx_fifo_10g_pkg::FAB_W50: r.data = {14'h0, d[49:0]};
			pcs_tx_fifo_10g_pkg::FAB_W64: r.data = d;
			pcs_tx_fifo_10g_pkg::FAB_W66: r.ctrl = {7'h00, c[1:0]}; // [R9]
			pcs_tx_fifo_10g_pkg::FAB_W67: r.ctrl = {6'h00, c[2:0]}; // [R10]
			default: r.ctrl = c;
		endcase
		return r;
	endfunction

	// Threshold value once this edge has passed, so a rewrite never leaves a flag a cycle stale
	function automatic logic [`TXF_AW-1:0] thr_next(
		input logic [`TXF_AW-1:0] cur,
		input logic [7:0] ofs
	);
		return (i_reg_wr && (i_reg_addr == ofs)) ? i_reg_wdata[`TXF_AW-1:0] : cur;
	endfunction

	pcs_tx_fifo_10g_pkg::ctrl_reg_t ctrl_q;
	logic [`TXF_AW-1:0] thr_full_q;
	logic [`TXF_AW-1:0] thr_empty_q;
	logic [`TXF_AW-1:0] thr_pfull_q;
	logic [`TXF_AW-1:0] thr_pempty_q;
	logic [`TXF_AW-1:0] thr_full_d;
	logic [`TXF_AW-1:0] thr_empty_d;
	logic [`TXF_AW-1:0] thr_pfull_d;
	logic [`TXF_AW-1:0] thr_pempty_d;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_en_q;
	logic [31:0] rdata_q;
	logic [`TXF_WIDTH-1:0] mem [`TXF_DEPTH];
	logic [`TXF_AW-1:0] wptr_q;
	logic [`TXF_AW-1:0] rptr_q;
	logic [`TXF_LW-1:0] lvl_q;
	logic [`TXF_LW-1:0] lvl_d;
	logic [`TXF_WIDTH-1:0] word_q;
	logic valid_q;
	pcs_tx_fifo_10g_pkg::fifo_flags_t flags_q;
	logic [2:0] stretch_q;
	logic bypass;
	logic wr_try;
	logic rd_try;
	logic wr_en;
	logic rd_en;
	logic [`TXF_WIDTH-1:0] in_word;
	logic [`TXF_WIDTH-1:0] out_src;
	logic [1:0] irq_evt;

	assign bypass = (ctrl_q.mode == pcs_tx_fifo_10g_pkg::MODE_REGISTER);
	assign in_word = form_word(ctrl_q.fabric_width, i_tx_data, i_tx_ctrl);

	// Write accepted only while a slot is free; overruns are refused, not wrapped
	assign wr_try = i_tx_data_valid && !bypass; // [R4]
	assign wr_en = wr_try && (lvl_q != 6'h20); // [R3]
	// Interlaken waits for the frame generator; phase comp drains on every held word
	always_comb begin
		case (ctrl_q.mode)
			pcs_tx_fifo_10g_pkg::MODE_INTERLAKEN: rd_try = i_rd_req; // [R5]
			pcs_tx_fifo_10g_pkg::MODE_PHASE_COMP: rd_try = (lvl_q != 6'h00); // [R6]
			default: rd_try = 1'b0;
		endcase
	end
	assign rd_en = rd_try && (lvl_q != 6'h00);
	assign irq_evt = {rd_try && !rd_en, wr_try && !wr_en};

	// Storage array, written on the write side only
	always_ff @(posedge i_clk) begin
		if (wr_en) begin
			mem[wptr_q] <= in_word; // [R1]
		end
	end

	// Pointers wrap naturally at 32
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wptr_q <= 5'h00;
			rptr_q <= 5'h00;
		end else begin
			wptr_q <= wptr_q + 5'(wr_en);
			rptr_q <= rptr_q + 5'(rd_en);
		end
	end

	// Occupancy from both strobes, so flags see the next level without a cycle of lag
	always_comb begin
		lvl_d = lvl_q;
		if (wr_en && !rd_en) begin
			lvl_d = lvl_q + 6'h01;
		end else if (rd_en && !wr_en) begin
			lvl_d = lvl_q - 6'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lvl_q <= 6'h00;
		end else begin
			lvl_q <= lvl_d; // [R1]
		end
	end

	// Output stage: store head, or the fabric word itself when bypassed
	assign out_src = bypass ? in_word : mem[rptr_q];

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			word_q <= '0;
			valid_q <= 1'b0;
		end else if (bypass) begin
			word_q <= ctrl_q.invert ? ~out_src : out_src; // [R7] [R12]
			valid_q <= i_tx_data_valid; // [R7] [R8]
		end else begin
			valid_q <= rd_en;
			if (rd_en) begin
				word_q <= ctrl_q.invert ? ~out_src : out_src; // [R12]
			end
		end
	end

	assign o_tx_word = word_q;
	assign o_tx_word_valid = valid_q;
	assign o_pma_width = ctrl_q.pma_width; // [R11]

	// Next thresholds; a flag compares level and threshold of the same cycle
	assign thr_full_d = thr_next(thr_full_q, `TXF_OFS_THR_FULL);
	assign thr_empty_d = thr_next(thr_empty_q, `TXF_OFS_THR_EMPTY);
	assign thr_pfull_d = thr_next(thr_pfull_q, `TXF_OFS_THR_PFULL);
	assign thr_pempty_d = thr_next(thr_pempty_q, `TXF_OFS_THR_PEMPTY);

	// Threshold flags, registered from the next level
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			flags_q <= '0;
		end else begin
			flags_q.full <= (lvl_d >= {1'b0, thr_full_d}); // [R13] [R14]
			flags_q.partial_full <= (lvl_d >= {1'b0, thr_pfull_d}); // [R2] [R16]
			flags_q.empty <= (lvl_d <= {1'b0, thr_empty_d}); // [R13] [R15]
			flags_q.partial_empty <= (lvl_d <= {1'b0, thr_pempty_d}); // [R2]
		end
	end

	// Empty is held a few read cycles so a slow reader cannot miss a short dip
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stretch_q <= `TXF_EMPTY_STRETCH;
		end else if (lvl_d <= {1'b0, thr_empty_d}) begin
			stretch_q <= `TXF_EMPTY_STRETCH; // [R17]
		end else if (stretch_q != 3'h0) begin
			stretch_q <= stretch_q - 3'h1; // [R17]
		end
	end

	assign o_transmit_fifo_full_flag = flags_q.full;
	assign o_transmit_fifo_partial_full_flag = flags_q.partial_full;
	assign o_transmit_fifo_empty_flag = (stretch_q != 3'h0);
	assign o_transmit_fifo_partial_empty_flag = flags_q.partial_empty;

	// Configuration registers
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_q <= `TXF_RST_CTRL;
			thr_full_q <= `TXF_RST_THR_FULL; // [R14]
			thr_empty_q <= `TXF_RST_THR_EMPTY; // [R15]
			thr_pfull_q <= `TXF_RST_THR_PFULL; // [R16]
			thr_pempty_q <= `TXF_RST_THR_PEMPTY;
			irq_en_q <= `TXF_RST_IRQ_EN;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`TXF_OFS_CTRL: ctrl_q <= i_reg_wdata[7:0]; // [R11]
				`TXF_OFS_THR_FULL: thr_full_q <= i_reg_wdata[4:0];
				`TXF_OFS_THR_EMPTY: thr_empty_q <= i_reg_wdata[4:0];
				`TXF_OFS_THR_PFULL: thr_pfull_q <= i_reg_wdata[4:0];
				`TXF_OFS_THR_PEMPTY: thr_pempty_q <= i_reg_wdata[4:0];
				`TXF_OFS_IRQ_EN: irq_en_q <= i_reg_wdata[1:0];
				default: ;
			endcase
		end
	end

	// Sticky events: bit0 overflow refused, bit1 read while empty; set beats clear
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_stat_q <= 2'h0;
		end else if (i_reg_wr && (i_reg_addr == `TXF_OFS_IRQ_CLR)) begin
			irq_stat_q <= (irq_stat_q & ~i_reg_wdata[1:0]) | irq_evt;
		end else begin
			irq_stat_q <= irq_stat_q | irq_evt; // [R3]
		end
	end

	assign o_irq = |(irq_stat_q & irq_en_q);

	// Read data one cycle after the strobe; unmapped and write-only read zero
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_q <= 32'h0000_0000;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				`TXF_OFS_CTRL: rdata_q <= {24'h00_0000, ctrl_q};
				`TXF_OFS_THR_FULL: rdata_q <= {27'h000_0000, thr_full_q};
				`TXF_OFS_THR_EMPTY: rdata_q <= {27'h000_0000, thr_empty_q};
				`TXF_OFS_THR_PFULL: rdata_q <= {27'h000_0000, thr_pfull_q};
				`TXF_OFS_THR_PEMPTY: rdata_q <= {27'h000_0000, thr_pempty_q};
				`TXF_OFS_STATUS: rdata_q <= {20'h0_0000, flags_q.partial_empty,
					o_transmit_fifo_empty_flag, flags_q.partial_full, flags_q.full,
					2'h0, lvl_q};
				`TXF_OFS_IRQ_STAT: rdata_q <= {30'h0000_0000, irq_stat_q};
				`TXF_OFS_IRQ_EN: rdata_q <= {30'h0000_0000, irq_en_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign o_reg_rdata = rdata_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	chk_depth_bound: assert property (lvl_q <= 6'h20) // [R1]
		else $error("fifo level above depth");
	chk_full_flag: assert property ( // [R14]
		o_transmit_fifo_full_flag == (lvl_q >= {1'b0, thr_full_q}))
		else $error("full flag disagrees with level");
	chk_pfull_flag: assert property ( // [R16]
		o_transmit_fifo_partial_full_flag == (lvl_q >= {1'b0, thr_pfull_q}))
		else $error("partial full flag disagrees with level");
	chk_empty_stretch: assert property ( // [R17]
		(lvl_q <= {1'b0, thr_empty_q}) ##1 (lvl_q > {1'b0, thr_empty_q})
		|-> o_transmit_fifo_empty_flag [*2])
		else $error("empty flag not stretched");
	chk_ilk_read: assert property ( // [R5]
		(ctrl_q.mode == pcs_tx_fifo_10g_pkg::MODE_INTERLAKEN) && !i_rd_req
		|=> !o_tx_word_valid)
		else $error("interlaken read without request");
	chk_pc_drain: assert property ( // [R6]
		(ctrl_q.mode == pcs_tx_fifo_10g_pkg::MODE_PHASE_COMP) && (lvl_q != 6'h00)
		|=> o_tx_word_valid)
		else $error("phase comp held word not drained");
	chk_reg_bypass: assert property ( // [R7]
		bypass && $stable(ctrl_q) ##1 bypass
		|-> o_tx_word_valid == $past(i_tx_data_valid))
		else $error("register mode valid not one stage");
	chk_overflow_evt: assert property ( // [R3]
		!bypass && i_tx_data_valid && (lvl_q == 6'h20)
		|=> irq_stat_q[0] && (lvl_q != 6'h00))
		else $error("overflow not refused and flagged");
	chk_w67_ctrl: assert property ( // [R10]
		bypass && !ctrl_q.invert && (ctrl_q.fabric_width == pcs_tx_fifo_10g_pkg::FAB_W67)
		##1 $stable(ctrl_q) |-> o_tx_word[72:64] == {6'h00, $past(i_tx_ctrl[2:0])})
		else $error("67-bit control lanes wrong");
	// Narrow widths zero the upper data before inversion, so only full-width data is compared
	chk_invert_out: assert property ( // [R12]
		bypass && ctrl_q.invert && (ctrl_q.fabric_width >= pcs_tx_fifo_10g_pkg::FAB_W64)
		##1 $stable(ctrl_q) |-> o_tx_word[63:0] == ~$past(i_tx_data))
		else $error("inversion not applied");

endmodule

// *** verification/fabric_writer_model.sv ***
// Fabric writer model: pushes a burst of words into the transmit FIFO.
// Assumes the FIFO clock and a one-cycle go pulse from the bench.
`timescale 1ns/1ns
`include "pcs_tx_fifo_10g_params.svh"
module fabric_writer_model (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_go,
	input wire logic [5:0] i_count,
	input wire logic [7:0] i_base,
	input wire logic i_ignore_full,
	input wire logic i_full,
	output logic [`TXF_DATA_W-1:0] o_tx_data,
	output logic [`TXF_CTRL_W-1:0] o_tx_ctrl,
	output logic o_tx_data_valid,
	output logic o_busy
);
	logic [5:0] left_q;
	logic [7:0] byte_q;

	assign o_busy = (left_q != 6'h00);

	// Burst engine; idle lanes flip so stale data never passes for a word
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			left_q <= 6'h00;
			byte_q <= 8'h00;
			o_tx_data <= '0;
			o_tx_ctrl <= '0;
			o_tx_data_valid <= 1'b0;
		end else if (!i_go && o_busy && (i_ignore_full || !i_full)) begin
			o_tx_data <= {8{byte_q}};
			o_tx_ctrl <= 9'h1FF;
			o_tx_data_valid <= 1'b1;
			byte_q <= byte_q + 8'h01;
			left_q <= left_q - 6'h01;
		end else begin
			o_tx_data <= ~o_tx_data;
			o_tx_ctrl <= ~o_tx_ctrl;
			o_tx_data_valid <= 1'b0;
			if (i_go) begin
				left_q <= i_count;
				byte_q <= i_base;
			end
		end
	end
endmodule

// *** verification/test_pcs_tx_fifo_10g.sv ***
// Bench for the transmit FIFO: register tasks, writer model, order and flag checks.
// Assumes the FIFO package and constants header are compiled first.
`timescale 1ns/1ns
`include "pcs_tx_fifo_10g_params.svh"
module test_pcs_tx_fifo_10g;
	logic i_clk, i_rst_b, i_rd_req, i_reg_wr, i_reg_rd, go, ign, busy, tx_valid;
	logic [5:0] cnt;
	logic [7:0] base, i_reg_addr;
	logic [31:0] i_reg_wdata, o_reg_rdata, rv;
	logic [63:0] tx_data;
	logic [8:0] tx_ctrl;
	logic [72:0] o_tx_word;
	logic o_tx_word_valid, o_irq, full, pfull, empty, pempty;
	logic [1:0] o_pma_width;
	int fail_count, n_checks, n_out;
	pcs_tx_fifo_10g_pkg::ctrl_reg_t cr;

	pcs_tx_fifo_10g dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_tx_data(tx_data),
		.i_tx_ctrl(tx_ctrl), .i_tx_data_valid(tx_valid), .i_rd_req(i_rd_req),
		.o_tx_word(o_tx_word), .o_tx_word_valid(o_tx_word_valid), .o_pma_width(o_pma_width),
		.o_transmit_fifo_full_flag(full), .o_transmit_fifo_partial_full_flag(pfull),
		.o_transmit_fifo_empty_flag(empty), .o_transmit_fifo_partial_empty_flag(pempty),
		.o_irq(o_irq), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
	fabric_writer_model writer_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_go(go), .i_count(cnt),
		.i_base(base), .i_ignore_full(ign), .i_full(full), .o_tx_data(tx_data),
		.o_tx_ctrl(tx_ctrl), .o_tx_data_valid(tx_valid), .o_busy(busy));

	// Clock, 8 ns period
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// Output words seen, to prove the writer never triggers reads
	// Counted on the falling edge, away from the edge that launches the pulse
	always @(negedge i_clk) if (o_tx_word_valid === 1'b1) n_out++;

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check_val(string name, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("MISMATCH %s exp %0h got %0h", name, e, g);
			fail_count++;
		end
	endtask

	task automatic check_word(string name, logic [72:0] e, logic [72:0] g);
		n_checks++;
		if (g !== e) begin
			$display("MISMATCH %s exp %0h got %0h", name, e, g);
			fail_count++;
		end
	endtask

	task automatic reg_wr(logic [7:0] a, logic [31:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask

	// Data stands only in the cycle after the strobe
	task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		#1 d = o_reg_rdata;
	endtask

	task automatic fail_wait(string name);
		$display("MISMATCH %s exp done got timeout", name);
		fail_count++;
		close_out();
	endtask

	task automatic push(logic [7:0] b, logic [5:0] n);
		@(posedge i_clk);
		go <= 1'b1;
		base <= b;
		cnt <= n;
		@(posedge i_clk);
		go <= 1'b0;
		for (int i = 0; i < 100; i++) begin
			@(posedge i_clk);
			#1 if (!busy) return;
		end
		fail_wait("push");
	endtask

	// Valid stands one cycle only: look before waiting, then just after each edge
	task automatic wait_valid();
		for (int i = 0; i < 20; i++) begin
			if (o_tx_word_valid === 1'b1) return;
			@(posedge i_clk);
			#1;
		end
		fail_wait("word_valid");
	endtask

	task automatic rd_one();
		@(posedge i_clk);
		i_rd_req <= 1'b1;
		@(posedge i_clk);
		i_rd_req <= 1'b0;
		#1;
	endtask

	// Expected word for a fabric width code; narrow widths drop upper data
	function automatic logic [72:0] shape(int w, logic [7:0] b, logic inv);
		logic [63:0] d;
		logic [8:0] c;
		d = {8{b}};
		c = 9'h000;
		case (w)
			0: d = {32'h0, d[31:0]};
			1: d = {24'h0, d[39:0]};
			2: d = {14'h0, d[49:0]};
			4: c = 9'h003;
			5: c = 9'h007;
			default: ;
		endcase
		return inv ? ~{c, d} : {c, d};
	endfunction

	// Main sequence
	initial begin
		{i_rst_b, i_rd_req, i_reg_wr, i_reg_rd, go, ign} = 6'h00;
		{cnt, base, i_reg_addr, i_reg_wdata} = '0;
		{fail_count, n_checks, n_out} = '0;
		repeat (8) @(posedge i_clk);
		i_rst_b <= 1'b1;
		reg_rd(`TXF_OFS_THR_FULL, rv);
		check_val("thr_full", 32'h1F, rv);
		reg_rd(`TXF_OFS_THR_EMPTY, rv);
		check_val("thr_empty", 32'h0, rv);
		reg_rd(`TXF_OFS_THR_PFULL, rv);
		check_val("thr_pfull", 32'h17, rv);
		check_val("empty_flag", 32'h1, {31'h0, empty});
		// Every fabric width through phase compensation, then the 32-bit width inverted
		for (int w = 0; w < 7; w++) begin
			cr = '0;
			cr.mode = pcs_tx_fifo_10g_pkg::MODE_PHASE_COMP;
			cr.fabric_width = pcs_tx_fifo_10g_pkg::fabric_width_t'(w % 6);
			cr.pma_width = pcs_tx_fifo_10g_pkg::pma_width_t'(w % 3);
			cr.invert = (w == 6);
			reg_wr(`TXF_OFS_CTRL, {24'h0, cr});
			push(8'h40 + 8'(w), 6'h01);
			wait_valid();
			check_word("shaped", shape(w % 6, 8'h40 + 8'(w), w == 6), o_tx_word);
			check_val("pma_width", 32'(w % 3), {30'h0, o_pma_width});
		end
		// Register mode bypasses the store
		cr = '0;
		cr.mode = pcs_tx_fifo_10g_pkg::MODE_REGISTER;
		cr.fabric_width = pcs_tx_fifo_10g_pkg::FAB_W64;
		reg_wr(`TXF_OFS_CTRL, {24'h0, cr});
		push(8'h5A, 6'h01);
		wait_valid();
		check_word("reg_word", shape(3, 8'h5A, 1'b0), o_tx_word);
		reg_rd(`TXF_OFS_STATUS, rv);
		check_val("reg_level", 32'h0, {26'h0, rv[5:0]});
		cr.fabric_width = pcs_tx_fifo_10g_pkg::FAB_W67;
		reg_wr(`TXF_OFS_CTRL, {24'h0, cr});
		push(8'h5B, 6'h01);
		wait_valid();
		check_word("reg_w67", shape(5, 8'h5B, 1'b0), o_tx_word);
		cr.fabric_width = pcs_tx_fifo_10g_pkg::FAB_W66;
		cr.invert = 1'b1;
		reg_wr(`TXF_OFS_CTRL, {24'h0, cr});
		push(8'h5C, 6'h01);
		wait_valid();
		check_word("reg_inv", shape(4, 8'h5C, 1'b1), o_tx_word);
		cr.fabric_width = pcs_tx_fifo_10g_pkg::FAB_W64;
		cr.invert = 1'b0;
		// Interlaken: fill to the full threshold, no reads without a request
		cr.mode = pcs_tx_fifo_10g_pkg::MODE_INTERLAKEN;
		reg_wr(`TXF_OFS_CTRL, {24'h0, cr});
		n_out = 0;
		push(8'h00, 6'd31);
		reg_rd(`TXF_OFS_STATUS, rv);
		check_val("fill_status", 32'h31F, {20'h0, rv[11:0]});
		check_val("fill_pins", 32'h3, {28'h0, pempty, empty, pfull, full});
		check_val("no_reads", 32'h0, 32'(n_out));
		@(posedge i_clk) ign <= 1'b1;
		push(8'h1F, 6'h02);
		@(posedge i_clk) ign <= 1'b0;
		reg_rd(`TXF_OFS_STATUS, rv);
		check_val("level_max", 32'h20, {26'h0, rv[5:0]});
		reg_rd(`TXF_OFS_IRQ_STAT, rv);
		check_val("overflow", 32'h1, rv);
		reg_wr(`TXF_OFS_IRQ_EN, 32'h3);
		#1 check_val("irq_on", 32'h1, {31'h0, o_irq});
		reg_wr(`TXF_OFS_IRQ_CLR, 32'h1);
		#1 check_val("irq_off", 32'h0, {31'h0, o_irq});
		// Drain in order, then one read too many
		for (int i = 0; i < 32; i++) begin
			rd_one();
			wait_valid();
			check_word("drain", shape(3, 8'(i), 1'b0), o_tx_word);
		end
		rd_one();
		reg_rd(`TXF_OFS_IRQ_STAT, rv);
		check_val("underrun", 32'h2, rv);
		reg_rd(`TXF_OFS_STATUS, rv);
		check_val("empty_status", 32'hC00, {20'h0, rv[11:0]});
		check_val("empty_pins", 32'hC, {28'h0, pempty, empty, pfull, full});
		reg_wr(`TXF_OFS_THR_FULL, 32'h0);
		reg_rd(`TXF_OFS_STATUS, rv);
		check_val("full_at_zero", 32'h1, {31'h0, rv[8]});
		close_out();
	end
endmodule
